// [hdl/timer_pkg.sv]
// Register indices, field positions and reset values of the capture/compare timer
// Assumes an APB slave with one 32-bit word per index (byte address = 4 * index)
package timer_pkg;

  // Register indices, one aligned word each
  localparam logic [5:0] IDX_STATUS_CONTROL       = 6'h20;
  localparam logic [5:0] IDX_COUNTER_HIGH         = 6'h22;
  localparam logic [5:0] IDX_COUNTER_LOW          = 6'h23;
  localparam logic [5:0] IDX_MODULO_HIGH          = 6'h24;
  localparam logic [5:0] IDX_MODULO_LOW           = 6'h25;
  localparam logic [5:0] IDX_CHAN0_STATUS_CONTROL = 6'h26;
  localparam logic [5:0] IDX_CHAN0_VALUE_HIGH     = 6'h27;
  localparam logic [5:0] IDX_CHAN0_VALUE_LOW      = 6'h28;
  localparam logic [5:0] IDX_CHAN1_STATUS_CONTROL = 6'h29;
  localparam logic [5:0] IDX_CHAN1_VALUE_HIGH     = 6'h2A;
  localparam logic [5:0] IDX_CHAN1_VALUE_LOW      = 6'h2B;
  localparam logic [5:0] IDX_CHAN2_STATUS_CONTROL = 6'h2C;
  localparam logic [5:0] IDX_CHAN2_VALUE_HIGH     = 6'h2D;
  localparam logic [5:0] IDX_CHAN2_VALUE_LOW      = 6'h2E;
  localparam logic [5:0] IDX_CHAN3_STATUS_CONTROL = 6'h2F;
  localparam logic [5:0] IDX_CHAN3_VALUE_HIGH     = 6'h30;
  localparam logic [5:0] IDX_CHAN3_VALUE_LOW      = 6'h31;

  // Per-channel index tables, channel 0 in the low slot
  localparam logic [3:0][5:0] IDX_CHAN_CTL = {IDX_CHAN3_STATUS_CONTROL, IDX_CHAN2_STATUS_CONTROL,
                                              IDX_CHAN1_STATUS_CONTROL, IDX_CHAN0_STATUS_CONTROL};
  localparam logic [3:0][5:0] IDX_CHAN_HI  = {IDX_CHAN3_VALUE_HIGH, IDX_CHAN2_VALUE_HIGH,
                                              IDX_CHAN1_VALUE_HIGH, IDX_CHAN0_VALUE_HIGH};
  localparam logic [3:0][5:0] IDX_CHAN_LO  = {IDX_CHAN3_VALUE_LOW, IDX_CHAN2_VALUE_LOW,
                                              IDX_CHAN1_VALUE_LOW, IDX_CHAN0_VALUE_LOW};

  // Decoded window and its one hole
  localparam logic [5:0] IDX_FIRST = 6'h20;
  localparam logic [5:0] IDX_LAST  = 6'h31;
  localparam logic [5:0] IDX_GAP   = 6'h21;

  // Status/control field positions
  localparam int BIT_OVF_FLAG = 7;
  localparam int BIT_OVF_IE   = 6;
  localparam int BIT_HALT     = 5;
  localparam int BIT_TRST     = 4;
  localparam int PS_MSB       = 2;

  // Channel status/control field positions
  localparam int BIT_CH_FLAG = 7;
  localparam int BIT_CH_IE   = 6;
  localparam int BIT_CH_MSB  = 5;
  localparam int BIT_CH_MSA  = 4;
  localparam int BIT_CH_ELSB = 3;
  localparam int BIT_CH_ELSA = 2;
  localparam int BIT_CH_TOV  = 1;
  localparam int BIT_CH_MAX  = 0;

  // Edge/level codes: capture edge or compare action
  localparam logic [1:0] ELS_OFF  = 2'h0;
  localparam logic [1:0] ELS_RISE = 2'h1;
  localparam logic [1:0] ELS_FALL = 2'h2;
  localparam logic [1:0] ELS_BOTH = 2'h3;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // Prescaler
  localparam logic [2:0] PS_EXTERNAL = 3'h7;
  localparam int         PRESC_WIDTH = 6;

  // Reset values and write masks
  localparam logic        HALT_RESET     = 1'b1;
  localparam logic [15:0] MODULO_RESET   = 16'hFFFF;
  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam logic [15:0] VALUE_RESET    = 16'h0000;
  localparam logic [7:0]  CTL_ODD_WMASK  = 8'hDF;

endpackage : timer_pkg

// [hdl/timer_prescaler.sv]
// Counter clock enable: seven divided bus-clock rates or edges of the external pin
// Assumes the external clock pin is synchronous to clk and well below clk/2
module timer_prescaler (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       clear,
  input  wire logic [2:0] select,
  input  wire logic       ext_clk_in,
  // Enable out
  output logic            tick
);

  typedef struct packed {
    logic [timer_pkg::PRESC_WIDTH-1:0] div;
    logic                              ext_prev;
    logic                              tick;
  } presc_t;

  presc_t s_q;
  presc_t s_d;

  // Mask of divider bits that must be all ones for a tick
  function automatic logic [5:0] div_mask(input logic [2:0] ps);
    case (ps)
      3'h0:    div_mask = 6'h00;
      3'h1:    div_mask = 6'h01;
      3'h2:    div_mask = 6'h03;
      3'h3:    div_mask = 6'h07;
      3'h4:    div_mask = 6'h0F;
      3'h5:    div_mask = 6'h1F;
      3'h6:    div_mask = 6'h3F;
      default: div_mask = 6'h00;
    endcase
  endfunction : div_mask

  // Divide by 1..64, or pass rising edges of the pin
  always_comb
  begin
    s_d          = s_q;
    s_d.div      = clear ? 6'h00 : s_q.div + 6'h01;
    s_d.ext_prev = ext_clk_in;
    if (select == timer_pkg::PS_EXTERNAL)
      s_d.tick = ext_clk_in && !s_q.ext_prev;
    else
      s_d.tick = !clear && ((s_q.div & div_mask(select)) == div_mask(select));
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

  AST_EXT_TICK: assert property (@(posedge clk) disable iff (!resetn)
    (select == timer_pkg::PS_EXTERNAL) && ext_clk_in && !s_q.ext_prev |=> tick)
    else $error("external clock edge gave no tick");

endmodule : timer_prescaler

// [hdl/capture_compare_timer.sv]
// Four-channel capture/compare timer on a 16-bit up-counter, APB register slave
// Assumes channel pin inputs and the external clock pin are synchronous to clk
//
// What this block does
// - A 16-bit up-counter, free or modulo, is the time base of all channels.
// - The counter wraps to zero after reaching the modulo register pair value.
// - Software reads the counter any time without disturbing the count.
// - Counter clock is one of seven bus-clock divisions or the external pin.
// - Each of four channels is independently input capture or output compare.
// - An active capture edge copies the counter into the channel value pair.
// - Capture edge is rising, falling or either, chosen per channel.
// - Counter equal to compare value sets, clears or toggles the channel pin.
// - Capture and compare events can raise the interrupt request.
// - Per channel, the pin can toggle on every counter overflow.
// - One control bit halts the counter, another resets it.
// - Unbuffered compares fire on equality only, never on passing a value.
// - Compare flag rises at the compare, overflow flag at the period end.
// - Buffered select in channel 0 links channels 0 and 1 onto pin 0.
// - Pair 0/1: channel 0 values first; last written pair takes over at overflow.
// - While linked, channel 0 control governs; channel 1 pin is released.
// - Buffered select in channel 2 links channels 2 and 3 onto pin 2.
// - Pair 2/3: channel 2 values first; last written pair takes over at overflow.
//
// Our own choice: the APB interface to the registers.
module capture_compare_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        external_timer_clock_pin,
  input  wire logic [3:0]  chan_pin_in,
  output logic      [3:0]  chan_pin_out,
  output logic      [3:0]  chan_pin_oe,
  // Interrupt request
  output logic             irq
);

  typedef struct packed {
    logic [15:0]      cnt;
    logic [15:0]      modulo;
    logic             ovf_flag;
    logic             ovf_ie;
    logic             halt;
    logic [2:0]       ps;
    logic [3:0][7:0]  ctl;
    logic [3:0][15:0] val;
    logic [3:0]       pin;
    logic [3:0]       pin_oe;
    logic [3:0]       pin_prev;
    logic [1:0]       wr_odd;
    logic [1:0]       act_odd;
    logic [7:0]       lo_buf;
    logic             lo_held;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
  } state_t;

  state_t      s_q;
  state_t      s_d;
  logic        tick;
  logic        trst_now;
  logic        bus_wr;
  logic        rd_setup;
  logic        ovf;
  logic [5:0]  idx;
  logic [3:0]  cap_ev;
  logic [3:0]  cmp_ev;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic [3:0]  slave;
  logic [3:0]  master;
  logic [15:0] cmp_val [4];

  // Address lies on a mapped, aligned register word
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'h0) && (a[7:2] >= timer_pkg::IDX_FIRST) &&
              (a[7:2] <= timer_pkg::IDX_LAST) && (a[7:2] != timer_pkg::IDX_GAP);
  endfunction : reg_hit

  // Channel configured as input capture
  function automatic logic ch_capture(input logic [7:0] c);
    ch_capture = !c[timer_pkg::BIT_CH_MSB] && !c[timer_pkg::BIT_CH_MSA] &&
                 (c[timer_pkg::BIT_CH_ELSB:timer_pkg::BIT_CH_ELSA] != timer_pkg::ELS_OFF);
  endfunction : ch_capture

  // Channel configured as a driven compare output, unbuffered or buffered
  function automatic logic ch_output(input logic [7:0] c);
    ch_output = (c[timer_pkg::BIT_CH_MSB] || c[timer_pkg::BIT_CH_MSA]) &&
                (c[timer_pkg::BIT_CH_ELSB:timer_pkg::BIT_CH_ELSA] != timer_pkg::ELS_OFF);
  endfunction : ch_output

  // Counter clock enable
  timer_prescaler u_prescaler (
    .clk        (clk),
    .resetn     (resetn),
    .clear      (trst_now),
    .select     (s_q.ps),
    .ext_clk_in (external_timer_clock_pin),
    .tick       (tick)
  );

  // Next state: counter, bus access, channels, flags
  always_comb
  begin
    s_d      = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    idx      = paddr[7:2];
    rd_setup = psel && !penable;
    bus_wr   = psel && penable && s_q.pready && pwrite && reg_hit(paddr);
    trst_now = bus_wr && (idx == timer_pkg::IDX_STATUS_CONTROL) && pwdata[timer_pkg::BIT_TRST];
    ovf      = 1'b0;
    cap_ev   = 4'h0;
    cmp_ev   = 4'h0;
    rise     = chan_pin_in & ~s_q.pin_prev;
    fall     = ~chan_pin_in & s_q.pin_prev;

    // Count on each enabled tick, wrap at the modulo value
    if (tick && !s_q.halt)
    begin
      if (s_q.cnt == s_q.modulo)
      begin
        s_d.cnt = 16'h0000;
        ovf     = 1'b1;
      end
      else
        s_d.cnt = s_q.cnt + 16'h0001;
    end

    // Setup phase: prepare read data and answer in the access phase
    if (rd_setup)
    begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !reg_hit(paddr);
      s_d.prdata  = 32'h0000_0000;
      if (reg_hit(paddr) && !pwrite)
      begin
        case (idx)
          timer_pkg::IDX_STATUS_CONTROL:
            s_d.prdata[7:0] = {s_q.ovf_flag, s_q.ovf_ie, s_q.halt, 2'b00, s_q.ps};
          timer_pkg::IDX_COUNTER_HIGH:
          begin
            s_d.prdata[7:0] = s_q.cnt[15:8];
            s_d.lo_buf      = s_q.cnt[7:0];
            s_d.lo_held     = 1'b1;
          end
          timer_pkg::IDX_COUNTER_LOW:
          begin
            s_d.prdata[7:0] = s_q.lo_held ? s_q.lo_buf : s_q.cnt[7:0];
            s_d.lo_held     = 1'b0;
          end
          timer_pkg::IDX_MODULO_HIGH:
            s_d.prdata[7:0] = s_q.modulo[15:8];
          timer_pkg::IDX_MODULO_LOW:
            s_d.prdata[7:0] = s_q.modulo[7:0];
          default:
            s_d.prdata[7:0] = 8'h00;
        endcase
        for (int i = 0; i < 4; i++)
        begin
          if (idx == timer_pkg::IDX_CHAN_CTL[i])
            s_d.prdata[7:0] = s_q.ctl[i];
          if (idx == timer_pkg::IDX_CHAN_HI[i])
            s_d.prdata[7:0] = s_q.val[i][15:8];
          if (idx == timer_pkg::IDX_CHAN_LO[i])
            s_d.prdata[7:0] = s_q.val[i][7:0];
        end
      end
    end

    // Access phase write; flags clear by writing zero to them
    if (bus_wr)
    begin
      case (idx)
        timer_pkg::IDX_STATUS_CONTROL:
        begin
          s_d.ovf_flag = s_q.ovf_flag & pwdata[timer_pkg::BIT_OVF_FLAG];
          s_d.ovf_ie   = pwdata[timer_pkg::BIT_OVF_IE];
          s_d.halt     = pwdata[timer_pkg::BIT_HALT];
          s_d.ps       = pwdata[timer_pkg::PS_MSB:0];
          if (trst_now)
            s_d.cnt = 16'h0000;
        end
        timer_pkg::IDX_MODULO_HIGH:
          s_d.modulo[15:8] = pwdata[7:0];
        timer_pkg::IDX_MODULO_LOW:
          s_d.modulo[7:0] = pwdata[7:0];
        default:
          s_d.modulo = s_d.modulo;
      endcase
      for (int i = 0; i < 4; i++)
      begin
        if (idx == timer_pkg::IDX_CHAN_CTL[i])
        begin
          s_d.ctl[i] = pwdata[7:0] & ((i % 2 == 1) ? timer_pkg::CTL_ODD_WMASK : 8'hFF);
          s_d.ctl[i][timer_pkg::BIT_CH_FLAG] = s_q.ctl[i][timer_pkg::BIT_CH_FLAG] &
                                               pwdata[timer_pkg::BIT_CH_FLAG];
          // Linking a pair hands the output to the even channel first
          if ((i % 2 == 0) && pwdata[timer_pkg::BIT_CH_MSB] &&
              !s_q.ctl[i][timer_pkg::BIT_CH_MSB])
            s_d.act_odd[i / 2] = 1'b0;
        end
        if (idx == timer_pkg::IDX_CHAN_HI[i])
        begin
          s_d.val[i][15:8]  = pwdata[7:0];
          s_d.wr_odd[i / 2] = (i % 2 == 1);
        end
        if (idx == timer_pkg::IDX_CHAN_LO[i])
        begin
          s_d.val[i][7:0]   = pwdata[7:0];
          s_d.wr_odd[i / 2] = (i % 2 == 1);
        end
      end
    end

    // Overflow: flag and hand-over of buffered pairs
    if (ovf)
    begin
      s_d.ovf_flag = 1'b1;
      s_d.act_odd  = s_d.wr_odd;
    end

    // Channels
    for (int i = 0; i < 4; i++)
    begin
      master[i] = (i % 2 == 0) && s_q.ctl[i][timer_pkg::BIT_CH_MSB];
      slave[i]  = (i % 2 == 1) && s_q.ctl[i - (i % 2)][timer_pkg::BIT_CH_MSB];
      cmp_val[i] = (master[i] && s_q.act_odd[i / 2]) ? s_q.val[i | 1] : s_q.val[i];
      s_d.pin_prev[i] = chan_pin_in[i];

      // Input capture on the selected edge
      if (!slave[i] && ch_capture(s_q.ctl[i]))
      begin
        case (s_q.ctl[i][timer_pkg::BIT_CH_ELSB:timer_pkg::BIT_CH_ELSA])
          timer_pkg::ELS_RISE: cap_ev[i] = rise[i];
          timer_pkg::ELS_FALL: cap_ev[i] = fall[i];
          timer_pkg::ELS_BOTH: cap_ev[i] = rise[i] | fall[i];
          default:             cap_ev[i] = 1'b0;
        endcase
      end

      // Output compare: overflow toggle first, compare action last
      if (!slave[i] && ch_output(s_q.ctl[i]))
      begin
        if (ovf && s_q.ctl[i][timer_pkg::BIT_CH_TOV])
          s_d.pin[i] = s_q.ctl[i][timer_pkg::BIT_CH_MAX] ? 1'b1 : !s_q.pin[i];
        cmp_ev[i] = tick && !s_q.halt && (s_d.cnt == cmp_val[i]);
        if (cmp_ev[i])
        begin
          case (s_q.ctl[i][timer_pkg::BIT_CH_ELSB:timer_pkg::BIT_CH_ELSA])
            timer_pkg::ACT_TOGGLE: s_d.pin[i] = !s_q.pin[i];
            timer_pkg::ACT_CLEAR:  s_d.pin[i] = 1'b0;
            timer_pkg::ACT_SET:    s_d.pin[i] = 1'b1;
            default:               s_d.pin[i] = s_d.pin[i];
          endcase
        end
      end
      s_d.pin_oe[i] = !slave[i] && ch_output(s_d.ctl[i]) &&
                      !((i % 2 == 1) && s_d.ctl[i - (i % 2)][timer_pkg::BIT_CH_MSB]);

      // Event flags win over a clear in the same cycle
      if (cap_ev[i])
        s_d.val[i] = s_q.cnt;
      if (cap_ev[i] || cmp_ev[i])
        s_d.ctl[i][timer_pkg::BIT_CH_FLAG] = 1'b1;
    end

    // Interrupt request from enabled flags
    s_d.irq = s_d.ovf_flag && s_d.ovf_ie;
    for (int i = 0; i < 4; i++)
    begin
      if (s_d.ctl[i][timer_pkg::BIT_CH_FLAG] && s_d.ctl[i][timer_pkg::BIT_CH_IE])
        s_d.irq = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q        <= '0;
      s_q.halt   <= timer_pkg::HALT_RESET;
      s_q.modulo <= timer_pkg::MODULO_RESET;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from the state register
  assign prdata       = s_q.prdata;
  assign pready       = s_q.pready;
  assign pslverr      = s_q.pslverr;
  assign chan_pin_out = s_q.pin;
  assign chan_pin_oe  = s_q.pin_oe;
  assign irq          = s_q.irq;

  // Counter, overflow and link checks
  AST_CNT_STEP: assert property (@(posedge clk) disable iff (!resetn)
    tick && !s_q.halt && (s_q.cnt != s_q.modulo) && !trst_now
    |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("counter did not step by one");

  AST_CNT_WRAP: assert property (@(posedge clk) disable iff (!resetn)
    tick && !s_q.halt && (s_q.cnt == s_q.modulo) && !trst_now
    |=> (s_q.cnt == 16'h0000) && s_q.ovf_flag)
    else $error("counter did not wrap at modulo");

  AST_HALT_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    s_q.halt && !trst_now |=> $stable(s_q.cnt))
    else $error("halted counter moved");

  AST_TRST_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    trst_now |=> s_q.cnt == 16'h0000)
    else $error("counter reset bit ignored");

  AST_CNT_LATCH: assert property (@(posedge clk) disable iff (!resetn)
    rd_setup && !pwrite && (paddr == {timer_pkg::IDX_COUNTER_HIGH, 2'b00})
    |=> pready && (prdata[7:0] == $past(s_q.cnt[15:8])) && (s_q.lo_buf == $past(s_q.cnt[7:0])))
    else $error("counter read not coherent");

  AST_OVF_IRQ: assert property (@(posedge clk) disable iff (!resetn)
    ovf && s_q.ovf_ie && !bus_wr |=> s_q.ovf_flag && irq)
    else $error("overflow gave no interrupt");

  AST_BUF_SWAP: assert property (@(posedge clk) disable iff (!resetn)
    ovf && !bus_wr |=> s_q.act_odd == $past(s_q.wr_odd))
    else $error("buffered pair not handed over at overflow");

  AST_LINK_FREE: assert property (@(posedge clk) disable iff (!resetn)
    s_q.ctl[0][timer_pkg::BIT_CH_MSB] |-> !chan_pin_oe[1])
    else $error("linked channel 1 pin still driven");

  // Per-channel event checks
  for (genvar g = 0; g < 4; g++)
  begin : g_chan_check
    AST_CAPTURE: assert property (@(posedge clk) disable iff (!resetn)
      cap_ev[g] |=> (s_q.val[g] == $past(s_q.cnt)) && s_q.ctl[g][timer_pkg::BIT_CH_FLAG])
      else $error("capture did not store the counter");

    AST_CMP_SET: assert property (@(posedge clk) disable iff (!resetn)
      cmp_ev[g] && (s_q.ctl[g][timer_pkg::BIT_CH_ELSB:timer_pkg::BIT_CH_ELSA] == timer_pkg::ACT_SET)
      |=> chan_pin_out[g])
      else $error("compare set action missing");

    AST_EVENT_IRQ: assert property (@(posedge clk) disable iff (!resetn)
      (cap_ev[g] || cmp_ev[g]) && s_q.ctl[g][timer_pkg::BIT_CH_IE] && !bus_wr |=> irq)
      else $error("enabled channel event gave no interrupt");
  end

endmodule : capture_compare_timer

// [verif/pin_partner.sv]
// Far side of the timer: event sources on the channel pins and the external clock pin
// Assumes the bench sets levels just after clock edges; a driven pin follows the timer
module pin_partner (
  // Clock
  input  wire logic       clk,
  // Bench stimulus
  input  wire logic [3:0] ev_level,
  input  wire logic       ext_level,
  // Timer pins
  input  wire logic [3:0] chan_pin_out,
  input  wire logic [3:0] chan_pin_oe,
  output logic      [3:0] chan_pin_in,
  output logic            ext_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin level: timer drive wins while enabled, else the event source
  assign chan_pin_in = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & ev_level);
  // External clock leaves just after a bus clock edge, like a synchronous source
  always_ff @(posedge clk) ext_pin <= ext_level;
endmodule : pin_partner

// [verif/testbench.sv]
// Self-checking bench of the capture/compare timer over APB
// Assumes a synchronous APB slave; every transfer waits for pready, the watchdog ends a hang
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus, pins and bench state
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        ext_level, ext_pin, pin_e;
  logic [7:0]  paddr, rd, lfsr_q, v;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ev_level, pin_in, pin_out, pin_oe;
  logic [1:0]  act;
  logic [15:0] c;
  int          fails, n_checks, ch;

  capture_compare_timer capture_compare_timer_inst (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_timer_clock_pin(ext_pin), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
    .chan_pin_oe(pin_oe), .irq(irq));
  pin_partner pin_partner_inst (
    .clk(clk), .ev_level(ev_level), .ext_level(ext_level), .chan_pin_out(pin_out),
    .chan_pin_oe(pin_oe), .chan_pin_in(pin_in), .ext_pin(ext_pin));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Expected pin after a compare action
  function automatic logic exp_pin(input logic [1:0] a, input logic old);
    if (a == timer_pkg::ACT_SET) return 1'b1;
    if (a == timer_pkg::ACT_CLEAR) return 1'b0;
    return ~old;
  endfunction : exp_pin

  // Expected capture for an edge code and edge direction
  function automatic logic exp_cap(input logic [1:0] a, input logic rising);
    return (a == timer_pkg::ELS_BOTH) || (rising ? a == timer_pkg::ELS_RISE
                                                 : a == timer_pkg::ELS_FALL);
  endfunction : exp_cap

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask : rdc

  // Halt and clear the counter with a modulo of 5
  task automatic start(input logic [7:0] st);
    wr(timer_pkg::IDX_STATUS_CONTROL, st);
    wr(timer_pkg::IDX_MODULO_HIGH, 8'h00);
    wr(timer_pkg::IDX_MODULO_LOW, 8'h05);
  endtask : start

  // Next state of the 8-bit stimulus shift register
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_step

  // Pseudo-random value 1..n
  task automatic rnd(input int n);
    lfsr_q = lfsr_step(lfsr_q);
    v = 8'(lfsr_q % n + 1);
  endtask : rnd

  // External clock pulses, one count each
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge clk);
      ext_level <= 1'b1;
      repeat (4) @(posedge clk);
      ext_level <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : pulses

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // Watchdog
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    test_done();
  end

  // Main sequence
  initial
  begin
    {resetn, psel, penable, pwrite, ext_level} = 5'h00;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    ev_level = 4'h0;
    lfsr_q   = 8'h54;
    fails    = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    // Reset values and the hole in the map
    rdc(timer_pkg::IDX_STATUS_CONTROL, 8'h20);
    rdc(timer_pkg::IDX_MODULO_HIGH, 8'hFF);
    rdc(timer_pkg::IDX_MODULO_LOW, 8'hFF);
    for (ch = 0; ch < 4; ch++) rdc(timer_pkg::IDX_CHAN_CTL[ch], 8'h00);
    rdc(timer_pkg::IDX_GAP, 8'h00);
    check(err, 1'b1);
    // External clock counting, wrap and overflow interrupt
    start(8'h77);
    wr(timer_pkg::IDX_STATUS_CONTROL, 8'h47);
    rnd(5);
    pulses(v);
    rdc(timer_pkg::IDX_COUNTER_HIGH, 8'h00);
    rdc(timer_pkg::IDX_COUNTER_LOW, v);
    pulses(6 - v);
    rdc(timer_pkg::IDX_STATUS_CONTROL, 8'hC7);
    check(irq, 1'b1);
    rdc(timer_pkg::IDX_COUNTER_LOW, 8'h00);
    // Compare actions on every channel: set, clear, toggle
    for (ch = 0; ch < 4; ch++)
    begin
      start(8'h37);
      rnd(5);
      // Compare values change only while the counter is halted and cleared
      wr(timer_pkg::IDX_CHAN_HI[ch], 8'h00);
      wr(timer_pkg::IDX_CHAN_LO[ch], v);
      pin_e = 1'b0;
      for (int a = 3; a >= 1; a--)
      begin
        act = 2'(a);
        wr(timer_pkg::IDX_CHAN_CTL[ch], {4'h5, act, 2'b00});
        if (a == 3)
        begin
          wr(timer_pkg::IDX_STATUS_CONTROL, 8'h07);
          pulses(v - 1);
          rdc(timer_pkg::IDX_CHAN_CTL[ch], {4'h5, act, 2'b00});
          check(pin_out[ch], 1'b0);
          pulses(1);
        end
        else
          pulses(6);
        pin_e = exp_pin(act, pin_e);
        check(pin_out[ch], pin_e);
        rdc(timer_pkg::IDX_CHAN_CTL[ch], {4'hD, act, 2'b00});
        check(irq, 1'b1);
      end
      wr(timer_pkg::IDX_CHAN_CTL[ch], 8'h00);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
    end
    // Capture edges on a random channel with the counter halted
    rnd(4);
    ch = v - 1;
    wr(timer_pkg::IDX_STATUS_CONTROL, 8'h10);
    repeat (v * 7) @(posedge clk);
    wr(timer_pkg::IDX_STATUS_CONTROL, 8'h20);
    apb(1'b0, timer_pkg::IDX_COUNTER_HIGH, 8'h00);
    c[15:8] = rd;
    apb(1'b0, timer_pkg::IDX_COUNTER_LOW, 8'h00);
    c[7:0] = rd;
    for (int a = 1; a <= 3; a++)
      for (int e = 1; e >= 0; e--)
      begin
        act = 2'(a);
        wr(timer_pkg::IDX_CHAN_CTL[ch], {4'h0, act, 2'b00});
        @(posedge clk);
        ev_level[ch] <= e[0];
        repeat (3) @(posedge clk);
        rdc(timer_pkg::IDX_CHAN_CTL[ch], {exp_cap(act, e[0]), 3'h0, act, 2'b00});
      end
    rdc(timer_pkg::IDX_CHAN_HI[ch], c[15:8]);
    rdc(timer_pkg::IDX_CHAN_LO[ch], c[7:0]);
    wr(timer_pkg::IDX_CHAN_CTL[ch], 8'h00);
    // Buffered pairs 0/1 and 2/3 with clear on compare and toggle on wrap
    for (int p = 0; p < 4; p += 2)
    begin
      start(8'h37);
      wr(timer_pkg::IDX_CHAN_HI[p], 8'h00);
      wr(timer_pkg::IDX_CHAN_LO[p], 8'h02);
      wr(timer_pkg::IDX_CHAN_HI[p + 1], 8'h00);
      wr(timer_pkg::IDX_CHAN_LO[p + 1], 8'h04);
      wr(timer_pkg::IDX_CHAN_CTL[p + 1], 8'h14);
      wr(timer_pkg::IDX_CHAN_CTL[p], 8'h2A);
      wr(timer_pkg::IDX_STATUS_CONTROL, 8'h07);
      check({pin_oe[p + 1], pin_oe[p]}, 2'b01);
      pulses(2);
      check(pin_out[p], 1'b0);
      pulses(4);
      check(pin_out[p], 1'b1);
      pulses(3);
      check(pin_out[p], 1'b1);
      pulses(1);
      check(pin_out[p], 1'b0);
      wr(timer_pkg::IDX_CHAN_CTL[p], 8'h00);
      wr(timer_pkg::IDX_CHAN_CTL[p + 1], 8'h00);
    end
    test_done();
  end
endmodule : testbench
